// ---- rtl/acs_sequencer.sv ----
// Calibration sequencer, the converter end of the link
// Requirements on this block and on its host
// RQ1: Calibration code write starts calibration anytime.
// RQ2: Code 01 runs zero then full self-cal.
// RQ3: Self zero step shorts input, programmed gain.
// RQ4: Self full step converts reference over gain.
// RQ5: Self-cal six periods, then mode clears.
// RQ6: Ready low nine periods after self command.
// RQ7: Ready high from start until new word.
// RQ8: Ready rises within one modulator cycle.
// RQ9: Host ignores ready one modulator cycle.
// RQ10: Bipolar self zero point means midscale.
// RQ11: Code 10 runs system zero-scale step.
// RQ12: Host applies zero input, zero first.
// RQ13: System step three periods, ready at four.
// RQ14: Code 11 runs system full-scale step.
// RQ15: Host holds full-scale input stable.
// RQ16: Bipolar system span from midscale up.
// RQ17: Lone step updates only its coefficient.
// RQ18: Results stored in zero and full registers.
// RQ19: Host recalibrates after gain or range change.
// RQ20: Durations scale inversely with master clock.
// RQ21: Setup reads back code while calibrating.
// RQ22: Code 00 is normal, coefficients untouched.
`timescale 1ns/1ps
`include "acs_defines.svh"
module acs_sequencer
   import acs_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // Register link
   acs_link_if.dev          link,
   // Modulator front end
   input  wire logic [15:0] mod_result,
   output logic             front_short,
   output logic             front_ref,
   output logic             front_bipolar,
   output logic [2:0]       front_gain,
   output logic [15:0]      zs_coef,
   output logic [15:0]      fs_coef,
   output logic [15:0]      data_word
);
   //------------------------------------------------------------
   // Modulator and output period timing
   //------------------------------------------------------------
   logic [7:0]  mod_cnt_ff;
   logic [15:0] odp_cnt_ff;
   logic        mod_tick;
   logic        odp_tick;
   // RQ20: all timing from master clock divider
   assign mod_tick = (mod_cnt_ff == 8'(`ACS_MOD_DIV - 8'h01));
   assign odp_tick = mod_tick && (odp_cnt_ff == 16'(`ACS_ODP_MODS - 16'h0001));
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mod_cnt_ff <= 8'h00;
      end else begin
         mod_cnt_ff <= mod_tick ? 8'h00 : 8'(mod_cnt_ff + 8'h01);
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         odp_cnt_ff <= 16'h0000;
      end else if (mod_tick) begin
         odp_cnt_ff <= odp_tick ? 16'h0000 : 16'(odp_cnt_ff + 16'h0001);
      end
   end
   //------------------------------------------------------------
   // Setup register
   //------------------------------------------------------------
   logic [7:0] setup_ff;
   logic       setup_wr;
   logic       cal_start;
   logic       cal_clear;
   acs_mode_t  wr_mode;
   assign setup_wr  = link.wr_stb && (link.reg_sel == `ACS_SETUP_IDX);
   assign wr_mode   = acs_mode_t'({link.wr_data[`ACS_MODE_HI_BIT], link.wr_data[`ACS_MODE_LO_BIT]});
   // RQ1: any calibration code starts, state ignored
   // RQ22: code zero starts nothing
   assign cal_start = setup_wr && (wr_mode != ACS_MODE_NORMAL);
   // RQ21: mode bits hold code until step ends
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         setup_ff <= `ACS_SETUP_RST;
      end else if (setup_wr) begin
         setup_ff <= link.wr_data;
      end else if (cal_clear) begin
         // RQ5: mode bits return to normal
         setup_ff[`ACS_MODE_HI_BIT] <= 1'b0;
         setup_ff[`ACS_MODE_LO_BIT] <= 1'b0;
      end
   end
   assign front_gain    = setup_ff[5:3];
   assign front_bipolar = setup_ff[`ACS_RANGE_BIT];
   //------------------------------------------------------------
   // Sequencer state machine
   //------------------------------------------------------------
   acs_state_t state_ff;
   acs_state_t nxt_state;
   acs_mode_t  mode_ff;
   logic [3:0] per_cnt_ff;
   logic [3:0] nxt_per;
   logic       step_end;
   assign step_end = odp_tick && (per_cnt_ff == 4'h1);
   always_comb begin
      nxt_state = state_ff;
      nxt_per   = per_cnt_ff;
      cal_clear = 1'b0;
      if (odp_tick && per_cnt_ff != 4'h0) begin
         nxt_per = 4'(per_cnt_ff - 4'h1);
      end
      case (state_ff)
         ACS_ST_IDLE: begin
            nxt_state = ACS_ST_IDLE;
         end
         // RQ3: self zero on shorted input
         ACS_ST_ZS: begin
            if (step_end) begin
               if (mode_ff == ACS_MODE_SELF) begin
                  // RQ2: zero step then full step
                  nxt_state = ACS_ST_FS;
                  nxt_per   = `ACS_STEP_ODP;
               end else begin
                  // RQ13: three periods, then one conversion
                  cal_clear = 1'b1;
                  nxt_state = ACS_ST_CONV;
                  nxt_per   = `ACS_SYS_CONV_ODP;
               end
            end
         end
         ACS_ST_FS: begin
            if (step_end) begin
               cal_clear = 1'b1;
               nxt_state = ACS_ST_CONV;
               // RQ6: three more conversion periods, nine total, for self-cal; one more, four total, for system full
               nxt_per   = (mode_ff == ACS_MODE_SELF) ? `ACS_CONV_ODP : `ACS_SYS_CONV_ODP;
            end
         end
         ACS_ST_CONV: begin
            if (step_end) begin
               nxt_state = ACS_ST_DONE;
            end
         end
         ACS_ST_DONE: begin
            nxt_state = ACS_ST_IDLE;
         end
         default: begin
            nxt_state = ACS_ST_IDLE;
         end
      endcase
      // Fresh command restarts from the top
      if (cal_start) begin
         // RQ11: code 10 opens zero step
         // RQ14: code 11 opens full step
         nxt_state = (wr_mode == ACS_MODE_SYS_FS) ? ACS_ST_FS : ACS_ST_ZS;
         nxt_per   = `ACS_STEP_ODP;
         cal_clear = 1'b0;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_ff   <= ACS_ST_IDLE;
         per_cnt_ff <= 4'h0;
      end else begin
         state_ff   <= nxt_state;
         per_cnt_ff <= nxt_per;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mode_ff <= ACS_MODE_NORMAL;
      end else if (cal_start) begin
         mode_ff <= wr_mode;
      end
   end
   // RQ3: input pair shorted to bias in self zero
   assign front_short = (state_ff == ACS_ST_ZS) && (mode_ff == ACS_MODE_SELF);
   // RQ4: internal reference over gain in self full
   assign front_ref   = (state_ff == ACS_ST_FS) && (mode_ff == ACS_MODE_SELF);
   //------------------------------------------------------------
   // Coefficients and data word
   //------------------------------------------------------------
   // RQ10: bipolar zero point is midscale, RQ16 likewise
   logic [15:0] zs_value;
   assign zs_value = front_bipolar ? 16'(mod_result - 16'h8000) : mod_result;
   // RQ18: zero result into zero register
   // RQ17: each step writes only its own
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         zs_coef <= `ACS_ZS_RST;
      end else if (state_ff == ACS_ST_ZS && step_end) begin
         zs_coef <= zs_value;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fs_coef <= `ACS_FS_RST;
      end else if (state_ff == ACS_ST_FS && step_end) begin
         fs_coef <= mod_result;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         data_word <= 16'h0000;
      end else if (state_ff == ACS_ST_CONV && step_end) begin
         data_word <= mod_result;
      end
   end
   //------------------------------------------------------------
   // Data ready and readback
   //------------------------------------------------------------
   // RQ7: high at start, low on new word
   // RQ8: rises the cycle after command, well inside one modulator cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         link.data_ready_n <= 1'b1;
      end else if (cal_start) begin
         link.data_ready_n <= 1'b1;
      end else if (state_ff == ACS_ST_DONE) begin
         link.data_ready_n <= 1'b0;
      end else if (link.rd_stb && link.reg_sel == 3'h3) begin
         // Data read consumes the word
         link.data_ready_n <= 1'b1;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         link.rd_data <= 8'h00;
      end else if (link.rd_stb) begin
         link.rd_data <= (link.reg_sel == `ACS_SETUP_IDX) ? setup_ff : 8'h00;
      end
   end
endmodule : acs_sequencer

// ---- rtl/acs_defines.svh ----
// Constants of the converter calibration sequencer
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH
// Setup register: index, reset value, fields
`define ACS_SETUP_IDX        3'h1
`define ACS_SETUP_RST        8'h01
`define ACS_MODE_HI_BIT      7
`define ACS_MODE_LO_BIT      6
`define ACS_RANGE_BIT        2
// Master clock divider to one modulator cycle
`define ACS_MOD_DIV          8'h80
// Output data periods in modulator cycles (plain default)
`define ACS_ODP_MODS         16'h0010
// Step lengths in output data periods
`define ACS_STEP_ODP         4'h3
`define ACS_CONV_ODP         4'h3
`define ACS_SYS_CONV_ODP     4'h1
// Coefficient reset values
`define ACS_ZS_RST           16'h8000
`define ACS_FS_RST           16'h5000
// Host register offsets on the bus
`define ACS_WB_CMD           4'h0
`define ACS_WB_STAT          4'h4
`define ACS_WB_ZS            4'h8
`define ACS_WB_FS            4'hc
`endif

// ---- rtl/acs_pkg.sv ----
// Types of the converter calibration sequencer
package acs_pkg;
   typedef enum logic [1:0] {
      ACS_MODE_NORMAL = 2'h0,
      ACS_MODE_SELF   = 2'h1,
      ACS_MODE_SYS_ZS = 2'h2,
      ACS_MODE_SYS_FS = 2'h3
   } acs_mode_t;
   typedef enum logic [4:0] {
      ACS_ST_IDLE = 5'h01,
      ACS_ST_ZS   = 5'h02,
      ACS_ST_FS   = 5'h04,
      ACS_ST_CONV = 5'h08,
      ACS_ST_DONE = 5'h10
   } acs_state_t;
endpackage : acs_pkg

// ---- rtl/acs_link_if.sv ----
// Register link between host controller and calibration sequencer
`timescale 1ns/1ps
interface acs_link_if;
   logic       wr_stb;
   logic       rd_stb;
   logic [2:0] reg_sel;
   logic [7:0] wr_data;
   logic [7:0] rd_data;
   logic       data_ready_n;
   modport dev  (input wr_stb, rd_stb, reg_sel, wr_data, output rd_data, data_ready_n);
   modport host (output wr_stb, rd_stb, reg_sel, wr_data, input rd_data, data_ready_n);
endinterface : acs_link_if

// ---- rtl/acs_host.sv ----
// Host controller end: Wishbone slave driving the register link
`timescale 1ns/1ps
`include "acs_defines.svh"
module acs_host
   import acs_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Register link
   acs_link_if.host         link
);
   //------------------------------------------------------------
   // Bus decode
   //------------------------------------------------------------
   logic req;
   logic busy_ff;
   logic ack_ff;
   logic data_ready_n_s1_ff;
   logic data_ready_n_ff;
   logic ign_on;
   logic [7:0] ign_cnt_ff;
   assign req = wb_cyc_i && wb_stb_i && !ack_ff;
   assign wb_ack_o = ack_ff;
   // One-cycle ack for every access
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req;
      end
   end
   // RQ12: host writes setup command only on command word
   assign link.wr_stb  = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `ACS_WB_CMD);
   assign link.wr_data = wb_dat_i[7:0];
   assign link.reg_sel = `ACS_SETUP_IDX;
   assign link.rd_stb  = req && !wb_we_i && (wb_adr_i == `ACS_WB_CMD);
   // Ready pin synchroniser
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         data_ready_n_s1_ff <= 1'b1;
         data_ready_n_ff    <= 1'b1;
      end else begin
         data_ready_n_s1_ff <= link.data_ready_n;
         data_ready_n_ff    <= data_ready_n_s1_ff;
      end
   end
   // RQ9: ignore ready one modulator cycle after command
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ign_cnt_ff <= 8'h00;
      end else if (link.wr_stb) begin
         ign_cnt_ff <= `ACS_MOD_DIV;
      end else if (ign_cnt_ff != 8'h00) begin
         ign_cnt_ff <= 8'(ign_cnt_ff - 8'h01);
      end
   end
   assign ign_on = (ign_cnt_ff != 8'h00);
   // RQ19: host tracks busy until ready returns
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy_ff <= 1'b0;
      end else if (link.wr_stb) begin
         busy_ff <= 1'b1;
      end else if (!ign_on && !data_ready_n_ff) begin
         busy_ff <= 1'b0;
      end
   end
   // Read data: status word only; every other address reads zero
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req && !wb_we_i) begin
         case (wb_adr_i)
            `ACS_WB_STAT: wb_dat_o <= {30'h0, !data_ready_n_ff, busy_ff};
            default:      wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end
endmodule : acs_host

// ---- verif/acs_link_checker.sv ----
// Link checker of the calibration sequencer pair
`timescale 1ns/1ps
module acs_link_checker (
   // Clock and reset
   input wire logic       clk,
   input wire logic       nrst,
   // Link signals
   input wire logic       wr_stb,
   input wire logic       rd_stb,
   input wire logic [2:0] reg_sel,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_data,
   input wire logic       data_ready_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic        cmd;
   logic [14:0] cnt_ff;
   logic [1:0]  md_ff;
   // Calibration code written into the setup register
   assign cmd = wr_stb && reg_sel == 3'h1 && wr_data[7:6] != 2'h0;
   // Cycles since the last command; saturates so late checks stay quiet
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         cnt_ff <= '0;
      else if (cmd)
         cnt_ff <= '0;
      else if (cnt_ff != 15'h7fff)
         cnt_ff <= cnt_ff + 15'h1;
   end
   // Mode of the last command
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         md_ff <= 2'h0;
      else if (cmd)
         md_ff <= wr_data[7:6];
   end
   sequence rdy_up;
      ##[0:128] data_ready_n;
   endsequence
   sequence rdy_hold;
      data_ready_n [*8];
   endsequence
   cal_start_a: assert property (cmd |-> rdy_up)
      else $error("ready not raised after command");
   ready_hold_a: assert property (cmd |-> ##129 rdy_hold)
      else $error("ready low early in calibration");
   cal_busy_a: assert property (md_ff != 2'h0 && cnt_ff > 15'd129 && cnt_ff < 15'd6144
      |-> data_ready_n)
      else $error("ready low inside first step");
   self_early_a: assert property (md_ff == 2'h1 && $fell(data_ready_n) |-> cnt_ff > 15'd16000)
      else $error("ready early after self calibration");
   self_late_a: assert property (md_ff == 2'h1 && cnt_ff == 15'd18700 |-> !data_ready_n)
      else $error("ready late after self calibration");
   sys_early_a: assert property (md_ff[1] && $fell(data_ready_n) |-> cnt_ff > 15'd6000)
      else $error("ready early after system step");
   sys_late_a: assert property (md_ff[1] && cnt_ff == 15'd8450 |-> !data_ready_n)
      else $error("ready late after system step");
   wr_pulse_a: assert property (wr_stb |=> !wr_stb)
      else $error("write strobe longer than one cycle");
   rd_pulse_a: assert property (rd_stb |=> !rd_stb)
      else $error("read strobe longer than one cycle");
   // Early in a step the setup byte must still carry the code
   readback_a: assert property (rd_stb && reg_sel == 3'h1 && md_ff != 2'h0 && cnt_ff < 15'd4000
      |=> rd_data[7:6] == md_ff)
      else $error("setup readback lost the calibration code");
endmodule : acs_link_checker

// ---- verif/adc_calibration_sequencer_bench.sv ----
// Bench of the calibration sequencer and its host controller
`timescale 1ns/1ps
`include "acs_defines.svh"
module adc_calibration_sequencer_bench;
   import acs_pkg::*;
   localparam int P = int'(`ACS_MOD_DIV) * int'(`ACS_ODP_MODS);
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic [31:0] dw = 32'h0;
   logic [15:0] mod_result = 16'h0;
   logic [15:0] va = 16'h0;
   logic [15:0] vb = 16'h0;
   logic        ack, fshort, fref, fbip;
   logic [2:0]  fgain;
   logic [31:0] dr, q;
   logic [15:0] zs, fs, dword;
   int          miscompares, tests_run, cycles, ez, ef;
   acs_link_if link_i ();
   acs_host acs_host_i (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
      .link(link_i));
   acs_sequencer acs_sequencer_i (.clk(clk), .nrst(nrst), .link(link_i),
      .mod_result(mod_result), .front_short(fshort), .front_ref(fref), .front_bipolar(fbip),
      .front_gain(fgain), .zs_coef(zs), .fs_coef(fs), .data_word(dword));
   acs_link_checker acs_link_checker_i (.clk(clk), .nrst(nrst), .wr_stb(link_i.wr_stb),
      .rd_stb(link_i.rd_stb), .reg_sel(link_i.reg_sel), .wr_data(link_i.wr_data),
      .rd_data(link_i.rd_data), .data_ready_n(link_i.data_ready_n));
   // --------------------------------------------------------------
   // Clock, modulator stand-in and hang guard
   // --------------------------------------------------------------
   always #12.5 clk = ~clk;
   // Reference step sees vb, any other step va
   always @(posedge clk) mod_result <= fref ? vb : va;
   // Whole run is about 41k cycles; cut off well beyond it
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         close_out();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Classic single cycle; read data taken at the ack edge
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dw <= d;
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      q = dr;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : wb
   // Command, front-end checks, then wait for the new word
   task automatic run(input logic [7:0] c, input int lo, input int hi);
      int t0;
      wb(1'b1, `ACS_WB_CMD, {24'h0, c});
      t0 = cycles;
      repeat (130) @(posedge clk);
      chk("ready_high", 1, link_i.data_ready_n);
      chk("short", c[7:6] == 2'h1, fshort);
      chk("ref", 0, fref);
      chk("gain", c[5:3], fgain);
      chk("bipolar", c[2], fbip);
      wb(1'b0, `ACS_WB_STAT, 32'h0);
      chk("busy", 1, q[0]);
      // Setup byte is latched on the link at the read edge
      wb(1'b0, `ACS_WB_CMD, 32'h0);
      chk("mode_read", c, link_i.rd_data);
      chk("cmd_read", 0, q);
      while (link_i.data_ready_n !== 1'b0 && cycles - t0 < hi + 10) @(posedge clk);
      chk("ready_delay", 1, cycles - t0 >= lo && cycles - t0 <= hi);
      chk("word", va, dword);
      // Host sees ready through two flops, then one more for busy
      repeat (4) @(posedge clk);
      wb(1'b0, `ACS_WB_STAT, 32'h0);
      chk("busy_end", 0, q[0]);
      chk("word_seen", 1, q[1]);
      wb(1'b0, `ACS_WB_CMD, 32'h0);
      chk("mode_clear", {2'h0, c[5:0]}, link_i.rd_data);
   endtask : run
   task automatic close_out();
      $display("Comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out
   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      ez = `ACS_ZS_RST;
      ef = `ACS_FS_RST;
      void'($urandom(32'h36d0));
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      chk("zs_rst", ez, zs);
      chk("fs_rst", ef, fs);
      chk("ready_rst", 1, link_i.data_ready_n);
      // Self calibration, bipolar, gain code 2
      va = 16'($urandom);
      vb = 16'($urandom);
      run(8'h54, 8 * P, 9 * P + 200);
      ez = 16'(va - 16'h8000);
      ef = vb;
      chk("zs_self", ez, zs);
      chk("fs_self", ef, fs);
      // Idle long enough for the late-ready check to look at the word
      repeat (300) @(posedge clk);
      // Coefficients sit on the front-end port only; the bus reads zero
      wb(1'b0, `ACS_WB_ZS, 32'h0);
      chk("zs_read", 0, q);
      // System zero step leaves the full-scale word alone
      // zero input set first
      va = 16'($urandom);
      run(8'h80, 3 * P, 4 * P + 200);
      ez = va;
      chk("zs_sys", ez, zs);
      chk("fs_keep", ef, fs);
      // Full step launched over a running zero step
      // input held through step
      va = 16'($urandom);
      wb(1'b1, `ACS_WB_CMD, 32'h80);
      repeat (200) @(posedge clk);
      run(8'hc0, 3 * P, 4 * P + 200);
      ef = va;
      chk("fs_sys", ef, fs);
      chk("zs_keep", ez, zs);
      // Normal mode touches no coefficient
      va = 16'($urandom);
      wb(1'b1, `ACS_WB_CMD, 32'h0);
      repeat (3 * P) @(posedge clk);
      chk("zs_norm", ez, zs);
      chk("fs_norm", ef, fs);
      wb(1'b0, 4'h2, 32'h0);
      chk("unmapped", 0, q);
      close_out();
   end
endmodule : adc_calibration_sequencer_bench
